// *** shared/wdc_consts.vh ***
/*
 * Constants for the watchdog control and status block: register offsets,
 * bit positions, reset patterns and timing counts.
 * Assumes a byte-wide register port and a 125 MHz core clock.
 */
`ifndef WDC_CONSTS_VH
`define WDC_CONSTS_VH

// Register offsets on the byte-wide register port.
`define WDC_ADDR_CLOCK_CONTROL   8'h8E
`define WDC_ADDR_TIMED_ACCESS    8'hC7
`define WDC_ADDR_WDT_CONTROL     8'hD8
`define WDC_ADDR_EXT_IRQ_ENABLE  8'hE8

// Watchdog control register bit positions.
`define WDC_BIT_BAUD_DOUBLE      7
`define WDC_BIT_POWER_ON         6
`define WDC_BIT_IRQ_FLAG         3
`define WDC_BIT_RESET_FLAG       2
`define WDC_BIT_RESET_ENABLE     1
`define WDC_BIT_RESTART          0

// Bits that need an open timed-access window to be written.
`define WDC_PROTECTED_MASK       8'h4B
// Bits that exist in the watchdog control register.
`define WDC_IMPLEMENTED_MASK     8'hCF
// Bits kept across an external reset (pattern 0x0x0xx0b).
`define WDC_EXT_RESET_KEEP_MASK  8'h56
// Value after a power-on reset: only the power-on flag set.
`define WDC_POWER_ON_VALUE       8'h40

// Extended interrupt enable register.
`define WDC_BIT_WDT_IRQ_ENABLE   4
`define WDC_EIE_RESERVED_MASK    8'hE0
`define WDC_EIE_WRITABLE_MASK    8'h1F

// Clock control register: upper two bits select the watchdog interval.
`define WDC_CLOCK_CONTROL_REG_SEL_HI         7
`define WDC_CLOCK_CONTROL_REG_SEL_LO         6

// Timed-access key bytes.
`define WDC_TA_KEY_FIRST         8'hAA
`define WDC_TA_KEY_SECOND        8'h55

// Timing: clocks per machine cycle and window length in machine cycles.
`define WDC_CLKS_PER_MCYCLE      4
`define WDC_TA_WINDOW_MCYCLES    3
`define WDC_TA_WINDOW_CLKS       (`WDC_CLKS_PER_MCYCLE * `WDC_TA_WINDOW_MCYCLES)

// Delay from time-out to watchdog reset, in clocks.
`define WDC_RESET_DELAY_CLKS     512
`define WDC_RESET_DELAY_W        10

// Default interval widths, in counter bits, for the four selections.
`define WDC_INTERVAL_SEL0        17
`define WDC_INTERVAL_SEL1        20
`define WDC_INTERVAL_SEL2        23
`define WDC_INTERVAL_SEL3        26

`endif

// *** design/wdc_timed_access.v ***
/*
 * Timed-access gate: watches writes to the key register and opens a short
 * window in which protected bits may be written.
 * Assumes single-cycle write strobes on the core clock.
 */
`timescale 1ns/1ps
`include "wdc_consts.vh"

module wdc_timed_access #(
  parameter WINDOW_CLKS = `WDC_TA_WINDOW_CLKS
) (
  // Clock and reset.
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       sync_rst_in,
  // Write observation.
  input  wire       wr_in,
  input  wire       key_sel_in,
  input  wire [7:0] wdata_in,
  // Window state.
  output wire       open_out
);

  reg       armed_q;
  reg [3:0] win_q;

  assign open_out = (win_q != 4'h0);

  // The second key byte must be the very next write; any other write disarms, except a first key byte to the key register, which re-arms.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed_q <= 1'b0;
      win_q   <= 4'h0;
    end else if (sync_rst_in) begin
      armed_q <= 1'b0;
      win_q   <= 4'h0;
    end else begin
      if (wr_in) begin
        armed_q <= key_sel_in && (wdata_in == `WDC_TA_KEY_FIRST);
      end
      if (wr_in && armed_q && key_sel_in && (wdata_in == `WDC_TA_KEY_SECOND)) begin
        win_q <= WINDOW_CLKS[3:0];
      end else if (win_q != 4'h0) begin
        win_q <= win_q - 4'h1;
      end
    end
  end

endmodule

// *** design/wdc_wdt_counter.v ***
/*
 * Watchdog interval counter: free-running on the core clock, signals a
 * time-out pulse when the selected interval has elapsed.
 * Assumes restart is a single-cycle pulse from the control logic.
 */
`timescale 1ns/1ps
`include "wdc_consts.vh"

module wdc_wdt_counter #(
  parameter WIDTH = `WDC_INTERVAL_SEL3,
  parameter SEL0  = `WDC_INTERVAL_SEL0,
  parameter SEL1  = `WDC_INTERVAL_SEL1,
  parameter SEL2  = `WDC_INTERVAL_SEL2,
  parameter SEL3  = `WDC_INTERVAL_SEL3
) (
  // Clock and reset.
  input  wire       clk_in,
  input  wire       rst_in,
  // Control.
  input  wire       restart_in,
  input  wire [1:0] sel_in,
  // Status.
  output reg        timeout_out
);

  reg  [WIDTH-1:0] count_q;
  reg  [WIDTH-1:0] limit;
  wire [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};

  // Limit is all ones over the selected number of low bits for selections 0 to 2, and over all WIDTH bits for selection 3.
  always @* begin
    case (sel_in)
      2'b00:   limit = (one << SEL0) - one;
      2'b01:   limit = (one << SEL1) - one;
      2'b10:   limit = (one << SEL2) - one;
      default: limit = {WIDTH{1'b1}};
    endcase
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q     <= {WIDTH{1'b0}};
      timeout_out <= 1'b0;
    end else if (restart_in) begin
      count_q     <= {WIDTH{1'b0}};
      timeout_out <= 1'b0;
    end else if (count_q >= limit) begin
      count_q     <= {WIDTH{1'b0}};
      timeout_out <= 1'b1;
    end else begin
      count_q     <= count_q + one;
      timeout_out <= 1'b0;
    end
  end

endmodule

// *** design/wdc_top.v ***
/*
 * Watchdog control and status block: watchdog control register, timed-access
 * protection, interval selection, interrupt enable and watchdog reset.
 * Assumes reset pins arrive asynchronously and the register port master
 * gives one-cycle strobes on the core clock.
 */
`timescale 1ns/1ps
`include "wdc_consts.vh"

module wdc_top #(
  parameter WDT_WIDTH  = `WDC_INTERVAL_SEL3,
  parameter WDT_SEL0   = `WDC_INTERVAL_SEL0,
  parameter WDT_SEL1   = `WDC_INTERVAL_SEL1,
  parameter WDT_SEL2   = `WDC_INTERVAL_SEL2,
  parameter WDT_SEL3   = `WDC_INTERVAL_SEL3
) (
  // Clock and power-on reset.
  input  wire       clk_in,
  input  wire       rst_in,
  // Reset pins from outside the clock domain.
  input  wire       ext_reset_in,
  input  wire       power_fail_reset_in,
  // Register port.
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  // Block outputs.
  output reg        uart1_baud_double_out,
  output reg        wdt_irq_out,
  output reg        wdt_reset_out,
  output reg        ta_window_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin synchronisers.
  // Both reset pins are levels from outside the core clock domain.
  // Each passes two flops before any logic looks at it, so a slow edge
  // cannot leave half the register file in reset and half out of it.
  // The cost is two clocks of latency, which no rule cares about.

  reg ext_meta_q;
  reg ext_sync_q;
  reg pf_meta_q;
  reg pf_sync_q;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      pf_meta_q  <= 1'b0;
      pf_sync_q  <= 1'b0;
    end else begin
      ext_meta_q <= ext_reset_in;
      ext_sync_q <= ext_meta_q;
      pf_meta_q  <= power_fail_reset_in;
      pf_sync_q  <= pf_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  // Decode is purely combinational on the address; the strobes qualify it.
  // Unmapped addresses decode to nothing and read back as zero.
  // Writes and reads are never both high, so one address decode serves both.

  wire sel_watchdog_control = (addr_in == `WDC_ADDR_WDT_CONTROL);
  wire sel_ta    = (addr_in == `WDC_ADDR_TIMED_ACCESS);
  wire sel_clock_control_reg = (addr_in == `WDC_ADDR_CLOCK_CONTROL);
  wire sel_eie   = (addr_in == `WDC_ADDR_EXT_IRQ_ENABLE);

  wire wr_watchdog_control  = wr_in && sel_watchdog_control;
  wire wr_clock_control_reg  = wr_in && sel_clock_control_reg;
  wire wr_eie    = wr_in && sel_eie;

  // The key register itself has no storage; a write to it only feeds
  // the timed-access gate, and a read of it returns zero.
  // The window length is counted in core clocks, four to a machine cycle.
  // A watchdog reset pulse also acts as a synchronous reset of the block.
  wire any_sync_rst;
  wire ta_open;

  wdc_timed_access #(
    .WINDOW_CLKS (`WDC_TA_WINDOW_CLKS)
  ) u_ta (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .sync_rst_in (any_sync_rst),
    .wr_in       (wr_in),
    .key_sel_in  (sel_ta),
    .wdata_in    (wdata_in),
    .open_out    (ta_open)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock control and extended interrupt enable registers.
  // Clock control is stored whole even though only its top two bits
  // matter here; the other bits belong to timers outside this block.
  // Interrupt enable keeps five bits; the upper three read back as ones.
  // Both registers return to zero on every reset source.

  reg [7:0] clock_control_reg_q;
  reg [4:0] eie_q;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clock_control_reg_q <= 8'h00;
      eie_q   <= 5'h00;
    end else if (any_sync_rst) begin
      clock_control_reg_q <= 8'h00;
      eie_q   <= 5'h00;
    end else begin
      if (wr_clock_control_reg) begin
        clock_control_reg_q <= wdata_in;
      end
      if (wr_eie) begin
        eie_q <= wdata_in[4:0];
      end
    end
  end

  wire       irq_enable = eie_q[`WDC_BIT_WDT_IRQ_ENABLE];
  wire [1:0] int_sel    = clock_control_reg_q[`WDC_CLOCK_CONTROL_REG_SEL_HI:`WDC_CLOCK_CONTROL_REG_SEL_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog control register.
  // The next value is worked out in one place so that every reset source,
  // software write and hardware event has a clear priority:
  // power-fail first, then watchdog reset, then external reset, then
  // ordinary operation. Within ordinary operation a software write comes
  // first, the restart bit then drops, and a time-out sets its flag last so
  // that hardware always wins a collision with a clearing write.

  reg  [7:0] watchdog_control_q;
  reg  [7:0] watchdog_control_d;
  wire       timeout;
  wire       wdt_fire;

  // Protected bits take the write only inside the window; other implemented bits always.
  wire [7:0] wmask = ta_open ? `WDC_IMPLEMENTED_MASK :
                     (`WDC_IMPLEMENTED_MASK & ~`WDC_PROTECTED_MASK);

  wire restart_req = wr_watchdog_control && ta_open && wdata_in[`WDC_BIT_RESTART];

  always @* begin
    watchdog_control_d = watchdog_control_q;
    if (pf_sync_q) begin
      watchdog_control_d = watchdog_control_q & `WDC_EXT_RESET_KEEP_MASK;
      watchdog_control_d[`WDC_BIT_RESET_FLAG] = 1'b0;
    end else if (wdt_reset_out) begin
      watchdog_control_d = watchdog_control_q & `WDC_EXT_RESET_KEEP_MASK;
      watchdog_control_d[`WDC_BIT_RESET_FLAG] = 1'b1;
    end else if (ext_sync_q) begin
      watchdog_control_d = watchdog_control_q & `WDC_EXT_RESET_KEEP_MASK;
    end else begin
      if (wr_watchdog_control) begin
        watchdog_control_d = (watchdog_control_q & ~wmask) | (wdata_in & wmask);
      end
      // Restart only lives for one cycle; the counter has taken it by then.
      if (!restart_req) begin
        watchdog_control_d[`WDC_BIT_RESTART] = 1'b0;
      end
      // Hardware set wins over a software clear in the same cycle.
      if (timeout) begin
        watchdog_control_d[`WDC_BIT_IRQ_FLAG] = 1'b1;
      end
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_control_q <= `WDC_POWER_ON_VALUE;
    end else begin
      watchdog_control_q <= watchdog_control_d;
    end
  end

  // The reset enable is read from the register itself, so clearing it
  // through an open window takes effect from the next clock.
  wire reset_enable = watchdog_control_q[`WDC_BIT_RESET_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // Interval counter.
  // The counter sees every reset source as a restart, so a fresh interval
  // always begins after any reset. Shorter interval widths can be given
  // as parameters to keep simulation short; the defaults are the real ones.

  assign any_sync_rst = ext_sync_q || pf_sync_q || wdt_reset_out;

  wdc_wdt_counter #(
    .WIDTH (WDT_WIDTH),
    .SEL0  (WDT_SEL0),
    .SEL1  (WDT_SEL1),
    .SEL2  (WDT_SEL2),
    .SEL3  (WDT_SEL3)
  ) u_cnt (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .restart_in  (restart_req || any_sync_rst),
    .sel_in      (int_sel),
    .timeout_out (timeout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Escalation from time-out to watchdog reset.
  // Once a time-out has been seen with the reset enable set, a fixed
  // delay runs before the reset pulse. Software can still save the
  // device by restarting the watchdog or clearing the enable during the
  // wait; either cancels the pending reset.

  reg                           pend_q;
  reg [`WDC_RESET_DELAY_W-1:0]  delay_q;
  localparam [31:0] DELAY_LAST_FULL = `WDC_RESET_DELAY_CLKS - 1;
  localparam [`WDC_RESET_DELAY_W-1:0] DELAY_LAST = DELAY_LAST_FULL[`WDC_RESET_DELAY_W-1:0];

  assign wdt_fire = pend_q && (delay_q == DELAY_LAST) && reset_enable;

  // A restart during the wait cancels the pending reset.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_q  <= 1'b0;
      delay_q <= {`WDC_RESET_DELAY_W{1'b0}};
    end else if (any_sync_rst || restart_req || !reset_enable) begin
      pend_q  <= 1'b0;
      delay_q <= {`WDC_RESET_DELAY_W{1'b0}};
    end else if (timeout && !pend_q) begin
      pend_q  <= 1'b1;
      delay_q <= {`WDC_RESET_DELAY_W{1'b0}};
    end else if (pend_q) begin
      delay_q <= delay_q + {{(`WDC_RESET_DELAY_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  // Every output comes straight from a flop. The flag outputs follow the
  // next value of the register so that they line up with what a read in
  // the following cycle returns. The window output is one clock late,
  // which is harmless since it is for observation only.
  // The reset pulse is a single clock wide; its own effect on this block
  // comes through the synchronous reset path in the next cycle.

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wdt_reset_out         <= 1'b0;
      wdt_irq_out           <= 1'b0;
      uart1_baud_double_out <= 1'b0;
      ta_window_out         <= 1'b0;
    end else begin
      wdt_reset_out         <= wdt_fire;
      wdt_irq_out           <= watchdog_control_d[`WDC_BIT_IRQ_FLAG] && irq_enable;
      uart1_baud_double_out <= watchdog_control_d[`WDC_BIT_BAUD_DOUBLE];
      ta_window_out         <= ta_open;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data in the cycle after the read strobe, zero when unmapped.
  // A read returns the register as it stood when the strobe was taken.
  // Outside the cycle after a read the data lines sit at zero, so a
  // careless sampler sees zero rather than stale data.

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      if (sel_watchdog_control) begin
        rdata_out <= watchdog_control_q & `WDC_IMPLEMENTED_MASK;
      end else if (sel_clock_control_reg) begin
        rdata_out <= clock_control_reg_q;
      end else if (sel_eie) begin
        rdata_out <= `WDC_EIE_RESERVED_MASK | {3'h0, eie_q};
      end else begin
        rdata_out <= 8'h00;
      end
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule

// *** tb/wdc_top_checker.sv ***
/* Port-level assertions for the watchdog control block.
   Assumes the bench keeps reset pins, key writes and window reloads apart. */
`timescale 1ns/1ps
module wdc_top_checker (
  // Clock and resets.
  input wire       clk_in,
  input wire       rst_in,
  input wire       ext_reset_in,
  input wire       power_fail_reset_in,
  // Register port.
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  // Block outputs.
  input wire       uart1_baud_double_out,
  input wire       wdt_irq_out,
  input wire       wdt_reset_out,
  input wire       ta_window_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reg [7:0] win_q;
  // Length of the current run of open-window cycles.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      win_q <= 8'h00;
    end else begin
      win_q <= ta_window_out ? win_q + 8'h01 : 8'h00;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !$past(rd_in) |-> rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_zero;
    rd_in && (addr_in == 8'h00 || addr_in == 8'hC7) |=> rdata_out == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
  property p_eie_rsvd;
    rd_in && addr_in == 8'hE8 |=> rdata_out[7:5] == 3'b111;
  endproperty
  a_eie_rsvd: assert property (p_eie_rsvd) else $error("reserved bits not high");
  property p_baud;
    wr_in && addr_in == 8'hD8 && !ext_reset_in && !power_fail_reset_in && !wdt_reset_out
      |=> uart1_baud_double_out == $past(wdata_in[7]);
  endproperty
  a_baud: assert property (p_baud) else $error("baud double not updated");
  property p_irq_gate;
    wr_in && addr_in == 8'hE8 && !wdata_in[4] |=> ##1 !wdt_irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq with enable low");
  property p_rst_pulse;
    wdt_reset_out |=> !wdt_reset_out ##1 !uart1_baud_double_out;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("watchdog reset pulse wrong");
  property p_ta_open;
    wr_in && addr_in == 8'hC7 && wdata_in == 8'hAA
      ##1 wr_in && addr_in == 8'hC7 && wdata_in == 8'h55 |=> ##1 ta_window_out;
  endproperty
  a_ta_open: assert property (p_ta_open) else $error("window did not open");
  property p_ta_len;
    $fell(ta_window_out) |-> win_q == 8'd12;
  endproperty
  a_ta_len: assert property (p_ta_len) else $error("window length wrong");
  property p_ext;
    ext_reset_in [*5] |-> !uart1_baud_double_out && !ta_window_out && !wdt_irq_out;
  endproperty
  a_ext: assert property (p_ext) else $error("external reset not applied");
  property p_pf;
    power_fail_reset_in [*5] |-> !ta_window_out && !wdt_irq_out;
  endproperty
  a_pf: assert property (p_pf) else $error("power-fail reset not applied");
endmodule
//////////////////////////////////////////////////////////////////////////////
bind wdc_top wdc_top_checker u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .ext_reset_in(ext_reset_in),
  .power_fail_reset_in(power_fail_reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .uart1_baud_double_out(uart1_baud_double_out), .wdt_irq_out(wdt_irq_out),
  .wdt_reset_out(wdt_reset_out), .ta_window_out(ta_window_out));

// *** tb/tb.sv ***
/* Self-checking bench for the watchdog control block.
   Assumes shortened intervals of 16, 32, 64 and 256 clocks. */
`timescale 1ns/1ps
module tb;
  reg         clk_in, rst_in, ext_reset_in, power_fail_reset_in, wr_in, rd_in, rd_d;
  reg  [7:0]  addr_in, wdata_in, d;
  reg  [15:0] q_e;
  reg  [15:0] expq[$];
  wire [7:0]  rdata_out;
  wire        baud, irq, wrst, win;
  integer     fail_count, cmp_count, cyc, t0, i, npulse;
  wdc_top #(.WDT_WIDTH(8), .WDT_SEL0(4), .WDT_SEL1(5), .WDT_SEL2(6), .WDT_SEL3(8)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .ext_reset_in(ext_reset_in),
    .power_fail_reset_in(power_fail_reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .uart1_baud_double_out(baud),
    .wdt_irq_out(irq), .wdt_reset_out(wrst), .ta_window_out(win));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      rd_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  // Masked expectation is queued; the monitor compares one cycle later.
  task rd(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      expq.push_back({m, e & m});
      addr_in <= a;
      rd_in <= 1'b1;
      wr_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task idle(input integer n);
    begin
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      repeat (n) @(posedge clk_in);
    end
  endtask
  task unlock;
    begin
      wr(8'hC7, 8'hAA);
      wr(8'hC7, 8'h55);
    end
  endtask
  task conclude;
    begin
      $display("compares=%0d failures=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) rd_d <= rd_in;
  always @(negedge clk_in) begin
    if (rd_d) begin
      q_e = expq.pop_front();
      chk(rdata_out & q_e[15:8], q_e[7:0]);
    end
  end
  // Pulse counter and hang guard; the run needs about 1600 cycles.
  always @(posedge clk_in) begin
    if (wrst === 1'b1) npulse = npulse + 1;
    cyc = cyc + 1;
    if (cyc == 6000) begin
      fail_count = fail_count + 1;
      conclude;
    end
  end
  initial begin
    {rst_in, ext_reset_in, power_fail_reset_in, wr_in, rd_in, rd_d} = 6'h20;
    {addr_in, wdata_in} = 16'h0000;
    {fail_count, cmp_count, cyc, npulse} = 0;
    d = $urandom(32'h8782ccc4);
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(8'hD8, 8'hF7, 8'h40);
    rd(8'hE8, 8'hFF, 8'hE0);
    wr(8'h8E, 8'hC0);
    wr(8'hD8, 8'hFF);
    rd(8'hD8, 8'hF7, 8'hC4);
    wr(8'hC7, 8'hAA);
    wr(8'hD8, 8'h00);
    wr(8'hC7, 8'h55);
    wr(8'hD8, 8'h80);
    rd(8'hD8, 8'hF7, 8'hC0);
    unlock;
    idle(11);
    wr(8'hD8, 8'h02);
    rd(8'hD8, 8'hF7, 8'h02);
    unlock;
    idle(12);
    wr(8'hD8, 8'h40);
    rd(8'hD8, 8'hF7, 8'h02);
    for (i = 0; i < 4; i = i + 1) begin
      d = $urandom;
      wr(8'hD8, d);
      idle(1);
      chk({7'h00, baud}, {7'h00, d[7]});
      rd(8'hD8, 8'h87, (d & 8'h84) | 8'h02);
    end
    wr(8'hE8, 8'h10);
    rd(8'hE8, 8'hFF, 8'hF0);
    unlock;
    wr(8'hD8, 8'h03);
    idle(2);
    rd(8'hD8, 8'hFF, 8'h02);
    t0 = 3;
    while (irq !== 1'b1 && t0 < 400) begin
      @(posedge clk_in);
      t0 = t0 + 1;
    end
    chk({7'h00, t0 >= 256 && t0 <= 260}, 8'h01);
    t0 = 0;
    while (wrst !== 1'b1 && t0 < 700) begin
      @(posedge clk_in);
      t0 = t0 + 1;
    end
    chk({7'h00, t0 >= 510 && t0 <= 516}, 8'h01);
    idle(2);
    rd(8'hD8, 8'hF7, 8'h06);
    rd(8'hE8, 8'hFF, 8'hE0);
    wr(8'hD8, 8'h84);
    ext_reset_in <= 1'b1;
    idle(5);
    ext_reset_in <= 1'b0;
    idle(4);
    rd(8'hD8, 8'hF7, 8'h06);
    power_fail_reset_in <= 1'b1;
    idle(5);
    power_fail_reset_in <= 1'b0;
    idle(4);
    rd(8'hD8, 8'hF7, 8'h02);
    unlock;
    wr(8'hD8, 8'h00);
    idle(1);
    npulse = 0;
    idle(700);
    chk(npulse[7:0], 8'h00);
    wr(8'hE8, 8'h10);
    idle(40);
    chk({7'h00, irq}, 8'h01);
    wr(8'hE8, 8'h00);
    idle(3);
    chk({7'h00, irq}, 8'h00);
    idle(2);
    conclude;
  end
endmodule
